// File: hw/pips_park_filter.sv
// Purpose: Synchronise and deglitch the power-good park input
// Assumes: Pin is asynchronous to clk_sys
// Notes:   Output changes only after input is stable for the full span
`default_nettype none
module pips_park_filter #(
    parameter int unsigned FILT_CYC = pips_pkg::PARK_FILT_CYC
) (
    // Clock, reset, enable
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic clk_en,
    // Pin and filtered level
    input  wire logic park_pin,
    output logic      park_filt_q
);
    import pips_pkg::*;

    // Elaboration check: the counter must be able to reach the span
    if (FILT_CYC < 1 || FILT_CYC >= (1 << FILT_CNT_W)) begin
        $error("pips_park_filter: FILT_CYC out of range");
    end

    logic                  sync1_q;   // First stage, read only by sync2
    logic                  sync2_q;   // Settled level
    logic [FILT_CNT_W-1:0] cnt_q;     // Stability counter

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    // Park resets high so a reset exit does not fake a falling edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q <= park_pin;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Deglitch filter
    // ------------------------------------------------------------
    // ignore slow-edge chatter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q       <= '0;
            park_filt_q <= 1'b1;
        end else if (clk_en) begin
            if (sync2_q == park_filt_q) begin
                // Agreeing level restarts the window
                cnt_q <= '0;
            end else if (cnt_q == FILT_CNT_W'(FILT_CYC)) begin
                park_filt_q <= sync2_q;
                cnt_q       <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/pips_pkg.sv
// Purpose: Shared constants for the power-up init and park sequencer
// Assumes: 40 MHz system clock
// Notes:   Times are kept in their own units; cycle counts derive from them
`default_nettype none
package pips_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 40_000_000;  // System clock rate
    localparam int unsigned PARK_FILT_NS   = 150;         // Slow-edge filter span
    // Least time rounds up
    localparam int unsigned PARK_FILT_CYC  = (PARK_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PARK_WIN_US    = 500;         // Park budget before supplies fail
    // Longest time rounds down
    localparam int unsigned PARK_WIN_CYC   = PARK_WIN_US * (CLK_HZ / 1_000_000);
    // ------------------------------------------------------------
    // Default step lengths of the init routine and counter widths
    // ------------------------------------------------------------
    localparam int unsigned PLL_LOCK_CYC   = 64;          // Plain default, no lock input
    localparam int unsigned CFG_WORDS      = 16;          // Plain default image size
    localparam int unsigned CFG_CNT_W      = 16;          // Word counter width
    localparam int unsigned FILT_CNT_W     = 8;           // Filter counter width
    localparam int unsigned PARK_CNT_W     = 16;          // Park counter width
    // ------------------------------------------------------------
    // Reset levels of outputs
    // ------------------------------------------------------------
    localparam logic        BUSY_IDLE      = 1'b0;        // Busy low while reset held
    localparam logic        OE_OFF         = 1'b1;        // Output enable is low-active
    localparam logic        OE_ON          = 1'b0;
    localparam logic        CS_IDLE        = 1'b1;        // Chip select idles high
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PIPS_RESET,
        PIPS_PLL_LOCK,
        PIPS_CFG_LOAD,
        PIPS_RUN,
        PIPS_PARKING,
        PIPS_PARKED
    } pips_state_e;
endpackage
`default_nettype wire

// File: hw/pips_top.sv
// Purpose: Power-up init sequencer with supply-fail park handshake
// Assumes: srst mirrors the board reset, already synchronous to clk_sys
// Notes:   Output enables are active low; high means released
`default_nettype none
module pips_top
    import pips_pkg::*;
#(
    parameter int unsigned LOCK_CYC  = pips_pkg::PLL_LOCK_CYC,
    parameter int unsigned CFG_LEN   = pips_pkg::CFG_WORDS,
    parameter int unsigned PARK_CYC  = pips_pkg::PARK_WIN_CYC
) (
    // Clock, reset, enable
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic clk_en,
    // Power monitor
    input  wire logic park_pin,
    // Flash word-fetch handshake from the flash reader
    input  wire logic cfg_word_done,
    output logic      cfg_fetch_req_q,
    // Status to host
    output logic      init_busy_output_q,
    output logic      init_busy_output_oe_n_q,
    output logic      park_active_q,
    output logic      parked_q,
    // Mirror and light control
    output logic      mirror_power_enable_q,
    output logic      mirror_power_enable_oe_n_q,
    output logic      light_driver_on_q,
    output logic      light_driver_on_oe_n_q,
    output logic      light_select_0_q,
    output logic      light_select_1_q,
    output logic      light_select_oe_n_q,
    // Serial flash pins
    output logic      flash_serial_clock_q,
    output logic      flash_serial_out_q,
    output logic      flash_chip_select_n_q,
    output logic      flash_oe_n_q,
    // Shared bidirectional data enable
    output logic      bidir_oe_n_q
);
    // Elaboration checks: larger counts would wrap the step counters
    if (LOCK_CYC < 1 || LOCK_CYC >= (1 << CFG_CNT_W)) begin
        $error("pips_top: LOCK_CYC out of range");
    end
    if (CFG_LEN < 1 || CFG_LEN >= (1 << CFG_CNT_W)) begin
        $error("pips_top: CFG_LEN out of range");
    end
    if (PARK_CYC < 1 || PARK_CYC >= (1 << PARK_CNT_W)) begin
        $error("pips_top: PARK_CYC out of range");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pips_state_e           state_q;      // Sequencer state
    pips_state_e           state_d;      // Next state
    logic                  park_filt;    // Filtered park level
    logic                  park_prev_q;  // For edge detection
    logic                  park_fall;    // Falling edge pulse
    logic [CFG_CNT_W-1:0]  step_cnt_q;   // Lock wait or word count
    logic [PARK_CNT_W-1:0] park_cnt_q;   // Park progress
    logic                  step_last;    // Current step finishes

    // ------------------------------------------------------------
    // Park input filter
    // ------------------------------------------------------------
    pips_park_filter #(
        .FILT_CYC (PARK_FILT_CYC)
    ) u_filt (
        .clk_sys     (clk_sys),
        .srst        (srst),
        .clk_en      (clk_en),
        .park_pin    (park_pin),
        .park_filt_q (park_filt)
    );

    // ------------------------------------------------------------
    // Park edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            park_prev_q <= 1'b1;
        end else if (clk_en) begin
            park_prev_q <= park_filt;
        end
    end

    assign park_fall = park_prev_q & ~park_filt;

    // ------------------------------------------------------------
    // Step end detection
    // ------------------------------------------------------------
    always_comb begin
        step_last = 1'b0;
        unique case (state_q)
            PIPS_PLL_LOCK: step_last = (step_cnt_q == CFG_CNT_W'(LOCK_CYC - 1));
            PIPS_CFG_LOAD: step_last = cfg_word_done && (step_cnt_q == CFG_CNT_W'(CFG_LEN - 1));
            PIPS_PARKING:  step_last = (park_cnt_q == PARK_CNT_W'(PARK_CYC - 1));
            PIPS_RESET,
            PIPS_RUN,
            PIPS_PARKED:   step_last = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PIPS_RESET:    state_d = PIPS_PLL_LOCK;
            PIPS_PLL_LOCK: if (step_last) state_d = PIPS_CFG_LOAD;
            PIPS_CFG_LOAD: if (step_last) state_d = PIPS_RUN;
            PIPS_RUN:      state_d = PIPS_RUN;
            PIPS_PARKING:  if (step_last) state_d = PIPS_PARKED;
            PIPS_PARKED:   state_d = PIPS_PARKED;
        endcase
        // Supply warning overrides any init step
        if (park_fall && state_q != PIPS_PARKING && state_q != PIPS_PARKED) begin
            state_d = PIPS_PARKING;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= PIPS_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Step counter for lock wait and config words
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            step_cnt_q <= '0;
        end else if (clk_en) begin
            if (state_d != state_q) begin
                step_cnt_q <= '0;
            end else if (state_q == PIPS_PLL_LOCK) begin
                step_cnt_q <= step_cnt_q + 1'b1;
            end else if (state_q == PIPS_CFG_LOAD && cfg_word_done) begin
                // Counts words as the flash reader delivers them
                step_cnt_q <= step_cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Park progress counter
    // ------------------------------------------------------------
    // Sized to the 500 us window the monitor guarantees
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            park_cnt_q <= '0;
        end else if (clk_en) begin
            if (state_q == PIPS_PARKING) begin
                park_cnt_q <= park_cnt_q + 1'b1;
            end else begin
                park_cnt_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Busy indicator
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            init_busy_output_q      <= BUSY_IDLE;
            init_busy_output_oe_n_q <= OE_ON;
        end else if (clk_en) begin
            init_busy_output_q <= (state_d == PIPS_PLL_LOCK) || (state_d == PIPS_CFG_LOAD);
        end
    end

    // ------------------------------------------------------------
    // Flash fetch request and flash pins
    // ------------------------------------------------------------
    // Pin toggling itself belongs to the flash reader; this holds the idle levels
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_fetch_req_q       <= 1'b0;
            flash_serial_clock_q  <= 1'b0;
            flash_serial_out_q    <= 1'b0;
            flash_chip_select_n_q <= CS_IDLE;
            flash_oe_n_q          <= OE_OFF;
        end else if (clk_en) begin
            cfg_fetch_req_q       <= (state_d == PIPS_CFG_LOAD);
            flash_chip_select_n_q <= (state_d != PIPS_CFG_LOAD);
            flash_oe_n_q          <= OE_ON;
        end
    end

    // ------------------------------------------------------------
    // Mirror and light control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mirror_power_enable_q      <= 1'b0;
            light_driver_on_q          <= 1'b0;
            light_select_0_q           <= 1'b0;
            light_select_1_q           <= 1'b0;
            mirror_power_enable_oe_n_q <= OE_OFF;
            light_driver_on_oe_n_q     <= OE_OFF;
            light_select_oe_n_q        <= OE_OFF;
        end else if (clk_en) begin
            mirror_power_enable_oe_n_q <= OE_ON;
            light_driver_on_oe_n_q     <= OE_ON;
            light_select_oe_n_q        <= OE_ON;
            // Mirror power stays up while parking so mirrors can settle
            mirror_power_enable_q      <= (state_d == PIPS_RUN) || (state_d == PIPS_PARKING);
            // Light off as soon as parking starts
            light_driver_on_q          <= (state_d == PIPS_RUN);
        end
    end

    // ------------------------------------------------------------
    // Bidirectional enable and park status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bidir_oe_n_q  <= OE_OFF;
            park_active_q <= 1'b0;
            parked_q      <= 1'b0;
        end else if (clk_en) begin
            bidir_oe_n_q  <= (state_d != PIPS_RUN);
            park_active_q <= (state_d == PIPS_PARKING);
            parked_q      <= (state_d == PIPS_PARKED);
        end
    end
endmodule
`default_nettype wire

// File: tb/pips_checker.sv
// Purpose: Port assertions for the init and park sequencer
// Assumes: Bound with LOCK_CYC 4, CFG_LEN 2, PARK_CYC 20
// Notes:   The lock repeat count is tied to a LOCK_CYC of 4
`default_nettype none
module pips_checker
    import pips_pkg::*;
#(
    parameter int unsigned LOCK_CYC = 4,
    parameter int unsigned CFG_LEN  = 2,
    parameter int unsigned PARK_CYC = 20
) (
    // Clock and inputs
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic park_pin,
    input wire logic cfg_word_done,
    // Sequencer outputs
    input wire logic cfg_fetch_req_q,
    input wire logic init_busy_output_q,
    input wire logic park_active_q,
    input wire logic parked_q,
    input wire logic mirror_power_enable_q,
    input wire logic light_driver_on_q,
    input wire logic flash_chip_select_n_q,
    input wire logic bidir_oe_n_q,
    input wire logic flash_oe_n_q,
    input wire logic mirror_power_enable_oe_n_q,
    input wire logic light_driver_on_oe_n_q,
    input wire logic light_select_oe_n_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [15:0] words_q;  // Words taken while loading
    logic [15:0] low_q;    // Consecutive low samples of the pin
    logic [15:0] park_q;   // Cycles spent parking
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Counters freeze with clk_en, like the sequencer itself
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            words_q <= 16'h0000;
            low_q   <= 16'h0000;
            park_q  <= 16'h0000;
        end else if (clk_en) begin
            words_q <= words_q + 16'((cfg_fetch_req_q & cfg_word_done) ? 1 : 0);
            low_q   <= park_pin ? 16'h0000 : low_q + 16'h0001;
            park_q  <= park_q + 16'(park_active_q ? 1 : 0);
        end
    end
    sequence lock_wait_s;
        !cfg_fetch_req_q [*4];
    endsequence
    sequence load_on_s;
        cfg_fetch_req_q && init_busy_output_q && !flash_chip_select_n_q;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reset_tristate_a: assert property (disable iff (1'b0)
        srst && clk_en |=> mirror_power_enable_oe_n_q && light_driver_on_oe_n_q && light_select_oe_n_q
            && flash_oe_n_q && bidir_oe_n_q && flash_chip_select_n_q && !init_busy_output_q)
        else $error("outputs not released during reset");
    release_active_a: assert property ($fell(srst) && clk_en |=> init_busy_output_q && !flash_oe_n_q
            && !mirror_power_enable_oe_n_q && !light_driver_on_oe_n_q)
        else $error("busy or enables wrong after release");
    lock_first_a: assert property ($rose(init_busy_output_q) |-> lock_wait_s ##1 load_on_s)
        else $error("config load not after lock time");
    busy_hold_a: assert property (init_busy_output_q && !cfg_word_done |=> init_busy_output_q)
        else $error("busy dropped without a word");
    busy_done_a: assert property ($fell(init_busy_output_q) |-> words_q == CFG_LEN && !cfg_fetch_req_q
            && flash_chip_select_n_q && mirror_power_enable_q && !bidir_oe_n_q)
        else $error("busy fell at wrong word count");
    park_filter_a: assert property ($rose(park_active_q) |-> low_q >= PARK_FILT_CYC + 1
            && low_q <= PARK_FILT_CYC + 6)
        else $error("park started off the filter span");
    park_quiet_a: assert property (park_active_q |-> !light_driver_on_q && bidir_oe_n_q)
        else $error("light or bidir active while parking");
    park_len_a: assert property ($rose(parked_q) |-> park_q == PARK_CYC && !mirror_power_enable_q)
        else $error("park length wrong");
endmodule
bind pips_top pips_checker #(.LOCK_CYC(LOCK_CYC), .CFG_LEN(CFG_LEN), .PARK_CYC(PARK_CYC)) pips_checker_i (
    .clk_sys, .srst, .clk_en, .park_pin, .cfg_word_done, .cfg_fetch_req_q, .init_busy_output_q,
    .park_active_q, .parked_q, .mirror_power_enable_q, .light_driver_on_q, .flash_chip_select_n_q,
    .bidir_oe_n_q, .flash_oe_n_q, .mirror_power_enable_oe_n_q, .light_driver_on_oe_n_q, .light_select_oe_n_q);
`default_nettype wire

// File: tb/pips_monitor_model.sv
// Purpose: Power monitor and flash reader beside the sequencer
// Assumes: Word pulses are one clock wide
// Notes:   Gap 0 gives back-to-back words, larger gaps a slow flash
`default_nettype none
module pips_monitor_model (
    // Clock and bench controls
    input  wire logic       clk_sys,
    input  wire logic       supply_fail,
    input  wire logic [3:0] word_gap,
    // Sequencer side
    input  wire logic       cfg_fetch_req_q,
    output logic            park_pin,
    output logic            cfg_word_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] gap_q;  // Cycles since the last word
    initial begin
        park_pin = 1'b1;
        cfg_word_done = 1'b0;
        gap_q = 4'h0;
    end
    always @(posedge clk_sys) begin
        park_pin <= !supply_fail;
    end
    // Reader answers only while a fetch is requested
    always @(posedge clk_sys) begin
        if (!cfg_fetch_req_q) begin
            gap_q <= 4'h0;
            cfg_word_done <= 1'b0;
        end else begin
            cfg_word_done <= (gap_q == word_gap);
            gap_q <= (gap_q == word_gap) ? 4'h0 : gap_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_pips_top.sv
// Purpose: Self-checking bench for the init and park sequencer
// Assumes: Shortened counts LOCK 4, CFG 2, PARK 20
// Notes:   Park drops are steered through the monitor model
`default_nettype none
module tb_pips_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LOCK  = 4;   // Shortened lock time
    localparam int WORDS = 2;   // Shortened image
    localparam int PARK  = 20;  // Shortened park time
    logic       clk_sys = 1'b0;
    logic       srst = 1'b1;
    logic       clk_en = 1'b1;
    logic       supply_fail = 1'b0;
    logic [3:0] word_gap = 4'h0;
    logic       park_pin, cfg_word_done, cfg_fetch_req_q, init_busy_output_q, init_busy_output_oe_n_q;
    logic       park_active_q, parked_q, mirror_power_enable_q, mirror_power_enable_oe_n_q;
    logic       light_driver_on_q, light_driver_on_oe_n_q, light_select_oe_n_q;
    logic       flash_chip_select_n_q, flash_oe_n_q, bidir_oe_n_q;
    logic       light_select_0_q, light_select_1_q, flash_serial_clock_q, flash_serial_out_q;
    int         mismatches = 0;
    int         num_checks = 0;
    int         cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    pips_top #(.LOCK_CYC(LOCK), .CFG_LEN(WORDS), .PARK_CYC(PARK)) pips_top_i (
        .clk_sys, .srst, .clk_en, .park_pin, .cfg_word_done, .cfg_fetch_req_q, .init_busy_output_q,
        .init_busy_output_oe_n_q, .park_active_q, .parked_q, .mirror_power_enable_q,
        .mirror_power_enable_oe_n_q, .light_driver_on_q, .light_driver_on_oe_n_q, .light_select_0_q,
        .light_select_1_q, .light_select_oe_n_q, .flash_serial_clock_q, .flash_serial_out_q,
        .flash_chip_select_n_q, .flash_oe_n_q, .bidir_oe_n_q);
    pips_monitor_model pips_monitor_model_i (
        .clk_sys, .supply_fail, .word_gap, .cfg_fetch_req_q, .park_pin, .cfg_word_done);
    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_cnt(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard, far above the roughly 130 cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset levels, then release with supplies and pin good
    task automatic reset_run();
        srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        check_bit("enables off", 1'b1, mirror_power_enable_oe_n_q & light_driver_on_oe_n_q
            & light_select_oe_n_q & flash_oe_n_q);
        check_bit("bidir input", 1'b1, bidir_oe_n_q & flash_chip_select_n_q);
        check_bit("busy idle", 1'b0, init_busy_output_q | init_busy_output_oe_n_q);
        check_bit("idle levels", 1'b0, light_select_0_q | light_select_1_q | flash_serial_clock_q
            | flash_serial_out_q);
        @(posedge clk_sys);
        srst <= 1'b0;
    endtask
    // Init with a flash reader of the given speed
    task automatic init_run(input logic [3:0] gap);
        int n;
        word_gap <= gap;
        @(posedge clk_sys);
        #1;
        check_bit("busy raised", 1'b1, init_busy_output_q);
        check_bit("pins active", 1'b0, flash_oe_n_q | mirror_power_enable_oe_n_q | light_driver_on_oe_n_q);
        n = 0;
        while (init_busy_output_q === 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // Reader needs gap+1 edges per word after the request, plus one to see it
        check_cnt("busy edges", LOCK + 1 + WORDS * (int'(gap) + 1), n);
        check_bit("run levels", 1'b1, mirror_power_enable_q & light_driver_on_q
            & flash_chip_select_n_q & !bidir_oe_n_q);
    endtask
    // Short drops up to the filter span must be ignored
    task automatic glitch_run();
        int lens [2] = '{1, pips_pkg::PARK_FILT_CYC};
        foreach (lens[i]) begin
            @(posedge clk_sys);
            supply_fail <= 1'b1;
            repeat (lens[i]) @(posedge clk_sys);
            supply_fail <= 1'b0;
            repeat (20) @(posedge clk_sys);
            #1;
            check_bit("glitch ignored", 1'b0, park_active_q);
        end
    endtask
    // Supply fail: park, then recover before the next release
    task automatic park_run();
        int n;
        @(posedge clk_sys);
        supply_fail <= 1'b1;
        n = 0;
        while (park_active_q !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_bit("park delay", 1'b1, n >= pips_pkg::PARK_FILT_CYC + 3 && n <= pips_pkg::PARK_FILT_CYC + 8);
        check_bit("park levels", 1'b1, !light_driver_on_q & bidir_oe_n_q & mirror_power_enable_q);
        // Freeze five edges: park progress must stall while clk_en is low
        @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        clk_en <= 1'b1;
        // Six edges spent so far, five of them frozen
        n = 6;
        while (parked_q !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_cnt("park edges", PARK + 5, n);
        check_bit("mirror off", 1'b0, mirror_power_enable_q);
        @(posedge clk_sys);
        supply_fail <= 1'b0;
        // pin good well before the next release
        repeat (12) @(posedge clk_sys);
    endtask
    // Main sequence, with a second reset after parking
    initial begin
        reset_run();
        init_run(4'h0);
        glitch_run();
        park_run();
        reset_run();
        init_run(4'h3);
        summarize();
    end
endmodule
`default_nettype wire
